// [rtl/icd_core.sv]
`timescale 1ns/100ps
module icd_core import icd_pkg::*; (
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        srst_i,
	// Avalon-MM slave
	input  wire logic [4:0]  avs_address_i,
	input  wire logic        avs_read_i,
	input  wire logic        avs_write_i,
	input  wire logic [31:0] avs_writedata_i,
	input  wire logic [3:0]  avs_byteenable_i,
	output logic      [31:0] avs_readdata_o,
	output logic             avs_waitrequest_o,
	// Execution status
	output logic             busy_o,
	output logic             done_o
);

	// Byte-lane merge of a write into an old word
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
		input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[i*8 +: 8] = wd[i*8 +: 8];
			end
		end
		return r;
	endfunction : merge

	// Clock count of a decoded instruction
	function automatic logic [CNT_W-1:0] cycles(input icd_dec_t d, input logic op32,
		input logic miss);
		logic [CNT_W-1:0] c;
		c = CYC_ONE;
		unique case (d.op)
			icd_cmp_mem_op: begin
				c = miss ? CYC_MEM_MISS : CYC_MEM_HIT;
			end
			icd_cmp_imm_op, icd_decrement_rm_op: begin
				if (!d.mem) begin
					c = CYC_ONE;
				end else begin
					c = miss ? CYC_MEM_MISS : CYC_MEM_HIT;
				end
			end
			icd_compare_exchange_op: begin
				c = (d.mem && miss) ? CYC_XCHG_MISS : CYC_XCHG_HIT;
			end
			icd_decimal_adjust_add_op, icd_decimal_adjust_sub_op: begin
				c = CYC_DECADJ;
			end
			icd_divide_op: begin
				if (!d.w) begin
					c = d.mem ? CYC_DIV_B_MEM : CYC_DIV_B_REG;
				end else if (!op32) begin
					c = d.mem ? CYC_DIV_W_MEM : CYC_DIV_W_REG;
				end else begin
					c = d.mem ? CYC_DIV_D_MEM : CYC_DIV_D_REG;
				end
			end
			default: begin
				c = CYC_ONE;
			end
		endcase
		return c;
	endfunction : cycles

	typedef enum logic [1:0] {
		icd_idle_st,
		icd_run_st
	} icd_state_t;

	icd_state_t       state_q;
	icd_state_t       state_d;
	icd_insn_t        insn_q;
	icd_arch_t        arch_q;
	icd_dec_t         exec_dec_q;
	logic             op32_q;
	logic             miss_q;
	logic             exec_op32_q;
	logic [CNT_W-1:0] cnt_q;
	logic [CNT_W-1:0] last_cyc_q;
	logic             done_q;
	logic             illegal_q;
	logic             wait_q;
	logic [31:0]      rdata_q;

	icd_dec_t         dec;
	icd_arch_t        exec_res;
	logic             req;
	logic             wr_fire;
	logic             wr_ctrl;
	logic             wr_insn;
	logic             wr_acc;
	logic             wr_data;
	logic             wr_flags;
	logic [31:0]      ctrl_wd;
	logic             start;
	logic             finish;
	logic [CNT_W-1:0] new_cyc;
	logic [31:0]      status_word;
	logic [31:0]      rmux;
	logic             running;
	logic             sel_ctrl;
	logic             sel_insn;
	logic             sel_acc;
	logic             sel_data;
	logic             sel_flags;
	logic             sel_status;
	logic             rd_take;
	logic             busy_d;
	logic             done_d;
	logic [31:0]      insn_wd;

	// Decode of the held instruction bytes
	icd_decode u_decode (
		.insn_i (insn_q),
		.dec_o  (dec)
	);

	// Architectural effect of the instruction in flight
	icd_exec u_exec (
		.op_i   (exec_dec_q.op),
		.op32_i (exec_op32_q),
		.st_i   (arch_q),
		.st_o   (exec_res)
	);

	// Register selects from the bus address, shared by writes and reads
	assign sel_ctrl   = avs_address_i == REG_CTRL;
	assign sel_insn   = avs_address_i == REG_INSN;
	assign sel_acc    = avs_address_i == REG_ACC;
	assign sel_data   = avs_address_i == REG_DATA;
	assign sel_flags  = avs_address_i == REG_FLAGS;
	assign sel_status = avs_address_i == REG_STATUS;

	// Bus strobes: a write commits on the edge that samples waitrequest low, one edge after its wait ends
	assign req      = avs_read_i | avs_write_i;
	assign wr_fire  = avs_write_i & ~wait_q;
	assign wr_ctrl  = wr_fire & sel_ctrl;
	assign wr_insn  = wr_fire & sel_insn;
	assign wr_acc   = wr_fire & sel_acc;
	assign wr_data  = wr_fire & sel_data;
	assign wr_flags = wr_fire & sel_flags;
	assign ctrl_wd  = merge(32'h0000_0000, avs_writedata_i, avs_byteenable_i);

	// Instruction bytes after a lane-merged write; the top byte is dropped
	assign insn_wd  = merge({8'h00, insn_q}, avs_writedata_i, avs_byteenable_i);

	// Only a read refreshes the read data, so it stands across writes
	assign rd_take  = avs_read_i & wait_q;

	// Start is ignored while an instruction runs
	assign running = state_q == icd_run_st;
	assign start   = wr_ctrl && ctrl_wd[CTRL_START] && !running;
	assign finish  = running && cnt_q == CYC_ONE;
	assign new_cyc = cycles(dec, wr_ctrl ? ctrl_wd[CTRL_OP32] : op32_q,
		wr_ctrl ? ctrl_wd[CTRL_MISS] : miss_q);

	// Next state
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			icd_idle_st: begin
				if (start) begin
					state_d = icd_run_st;
				end
			end
			icd_run_st: begin
				if (finish) begin
					state_d = icd_idle_st;
				end
			end
		endcase
	end

	// Status word and read mux
	assign status_word = {{(8-CNT_W){1'b0}}, last_cyc_q,
		{(8-FL_W){1'b0}}, exec_dec_q.mask,
		4'h0, exec_dec_q.op,
		5'h00, illegal_q, done_q, running};
	assign rmux = sel_ctrl   ? {29'h0000_0000, miss_q, op32_q, 1'b0} :
		sel_insn   ? {8'h00, insn_q} :
		sel_acc    ? arch_q.acc :
		sel_data   ? arch_q.dx :
		sel_flags  ? {{(32-FL_W){1'b0}}, arch_q.fl} :
		sel_status ? status_word : 32'h0000_0000;

	// Next values of the registered status outputs
	assign busy_d = state_d == icd_run_st;
	assign done_d = finish | (done_q & ~start);

	// Bus handshake: one wait cycle, then data and release
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			wait_q  <= 1'b1;
			rdata_q <= 32'h0000_0000;
		end else begin
			wait_q  <= ~(req & wait_q);
			rdata_q <= rd_take ? rmux : rdata_q;
		end
	end

	// Configuration and instruction bytes
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			insn_q <= '0;
			op32_q <= 1'b0;
			miss_q <= 1'b0;
		end else begin
			if (wr_insn && state_q == icd_idle_st) begin
				insn_q <= insn_wd[23:0];
			end
			if (wr_ctrl) begin
				op32_q <= ctrl_wd[CTRL_OP32];
				miss_q <= ctrl_wd[CTRL_MISS];
			end
		end
	end

	// Sequencer: latch decode and count its clocks down
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			state_q     <= icd_idle_st;
			exec_dec_q  <= '{op: icd_none_op, w: 1'b0, mem: 1'b0, legal: 1'b0, mask: MSK_NONE};
			exec_op32_q <= 1'b0;
			cnt_q       <= CYC_ONE;
			last_cyc_q  <= '0;
			illegal_q   <= 1'b0;
		end else begin
			state_q <= state_d;
			if (start) begin
				exec_dec_q  <= dec;
				exec_op32_q <= ctrl_wd[CTRL_OP32];
				cnt_q       <= new_cyc;
				last_cyc_q  <= new_cyc;
				illegal_q   <= ~dec.legal;
			end else if (state_q == icd_run_st) begin
				cnt_q <= cnt_q - CYC_ONE;
			end
		end
	end

	// Done: set on finish wins over the clear by a new start
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			done_q <= 1'b0;
		end else if (finish) begin
			done_q <= 1'b1;
		end else if (start) begin
			done_q <= 1'b0;
		end
	end

	// Architectural state; instruction results win over software writes
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			arch_q.acc <= 32'h0000_0000;
			arch_q.dx  <= 32'h0000_0000;
			arch_q.fl  <= FLAGS_RST;
		end else if (finish) begin
			arch_q <= exec_res;
		end else begin
			if (wr_acc) begin
				arch_q.acc <= merge(arch_q.acc, avs_writedata_i, avs_byteenable_i);
			end
			if (wr_data) begin
				arch_q.dx <= merge(arch_q.dx, avs_writedata_i, avs_byteenable_i);
			end
			if (wr_flags && avs_byteenable_i[0]) begin
				arch_q.fl <= avs_writedata_i[FL_W-1:0];
			end
		end
	end

	// Registered outputs
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			busy_o <= 1'b0;
			done_o <= 1'b0;
		end else begin
			busy_o <= busy_d;
			done_o <= done_d;
		end
	end

	assign avs_readdata_o    = rdata_q;
	assign avs_waitrequest_o = wait_q;

endmodule : icd_core

// [rtl/icd_decode.sv]
`timescale 1ns/100ps
module icd_decode import icd_pkg::*; (
	// Instruction bytes
	input  wire icd_insn_t insn_i,
	// Decoded result
	output icd_dec_t       dec_o
);

	// Full decode of one instruction window
	function automatic icd_dec_t decode(input icd_insn_t in);
		icd_dec_t d;
		d = '{op: icd_none_op, w: 1'b0, mem: 1'b0, legal: 1'b0, mask: MSK_NONE};
		if (in.b0 == OPC_CARRY_INV) begin
			d = '{icd_carry_invert_op, 1'b0, 1'b0, 1'b1, MSK_CARRY};
		end else if (in.b0[7:2] == PAT_CMP_RM) begin
			d.w     = in.b0[0];
			d.legal = 1'b1;
			d.mask  = MSK_ARITH;
			if (in.b1[7:6] == MOD_REG) begin
				d.op = icd_cmp_reg_op;
			end else begin
				d.op  = icd_cmp_mem_op;
				d.mem = 1'b1;
			end
		end else if (in.b0[7:1] == PAT_CMP_ACC) begin
			d = '{icd_cmp_acc_op, in.b0[0], 1'b0, 1'b1, MSK_ARITH};
		end else if (in.b0[7:2] == PAT_CMP_IMM && in.b1[5:3] == RF_CMP_IMM) begin
			d = '{icd_cmp_imm_op, in.b0[0], in.b1[7:6] != MOD_REG, 1'b1, MSK_ARITH};
		end else if (in.b0 == OPC_ESCAPE && in.b1[7:1] == PAT_XCHG) begin
			d = '{icd_compare_exchange_op, in.b1[0], in.b2[7:6] != MOD_REG, 1'b1,
				MSK_ARITH};
		end else if (in.b0 == OPC_SIGN_EXT) begin
			d = '{icd_word_sign_extend_op, 1'b1, 1'b0, 1'b1, MSK_NONE};
		end else if (in.b0 == OPC_DEC_ADD) begin
			d = '{icd_decimal_adjust_add_op, 1'b0, 1'b0, 1'b1, MSK_DECADJ};
		end else if (in.b0 == OPC_DEC_SUB) begin
			d = '{icd_decimal_adjust_sub_op, 1'b0, 1'b0, 1'b1, MSK_DECADJ};
		end else if (in.b0[7:1] == PAT_DEC_RM && in.b1[5:3] == RF_DEC) begin
			d = '{icd_decrement_rm_op, in.b0[0], in.b1[7:6] != MOD_REG, 1'b1,
				MSK_DECR};
		end else if (in.b0[7:3] == PAT_DEC_SHORT) begin
			d = '{icd_decrement_short_op, 1'b1, 1'b0, 1'b1, MSK_DECR};
		end else if (in.b0[7:1] == PAT_DIV && in.b1[5:3] == RF_DIV) begin
			d = '{icd_divide_op, in.b0[0], in.b1[7:6] != MOD_REG, 1'b1, MSK_NONE};
		end
		return d;
	endfunction : decode

	// Decoder output
	assign dec_o = decode(insn_i);

endmodule : icd_decode

// [rtl/icd_exec.sv]
`timescale 1ns/100ps
module icd_exec import icd_pkg::*; (
	// Operation
	input  wire icd_op_t   op_i,
	input  wire logic      op32_i,
	// State before and after
	input  wire icd_arch_t st_i,
	output icd_arch_t      st_o
);

	// Sign, zero, parity of a result byte
	function automatic logic [2:0] szp(input logic [7:0] v);
		return {v[7], v == 8'h00, ~^v};
	endfunction : szp

	logic [7:0] acc_lo;
	logic       carry_in;
	logic       aux_in;
	logic       low_fix;
	logic       high_fix;
	logic [8:0] add_lo;
	logic [8:0] sub_lo;
	logic [7:0] add_res;
	logic [7:0] sub_res;
	logic [2:0] add_szp;
	logic [2:0] sub_szp;

	// Correction decisions on the original byte
	assign acc_lo   = st_i.acc[7:0];
	assign carry_in = st_i.fl[FL_CARRY];
	assign aux_in   = st_i.fl[FL_AUX];
	assign low_fix  = (acc_lo[3:0] > DA_LOW_MAX) || aux_in;
	assign high_fix = (acc_lo > DA_BYTE_MAX) || carry_in;
	assign add_lo   = {1'b0, acc_lo} + (low_fix ? {1'b0, DA_LOW_FIX} : 9'h000);
	assign sub_lo   = {1'b0, acc_lo} - (low_fix ? {1'b0, DA_LOW_FIX} : 9'h000);
	assign add_res  = add_lo[7:0] + (high_fix ? DA_HIGH_FIX : 8'h00);
	assign sub_res  = sub_lo[7:0] - (high_fix ? DA_HIGH_FIX : 8'h00);
	assign add_szp  = szp(add_res);
	assign sub_szp  = szp(sub_res);

	// Result selection; unlisted flags keep their value
	always_comb begin
		st_o = st_i;
		unique case (op_i)
			icd_carry_invert_op: begin
				st_o.fl[FL_CARRY] = ~carry_in;
			end
			icd_word_sign_extend_op: begin
				if (op32_i) begin
					st_o.dx = {32{st_i.acc[31]}};
				end else begin
					st_o.dx[15:0] = {16{st_i.acc[15]}};
				end
			end
			icd_decimal_adjust_add_op: begin
				st_o.acc[7:0]  = add_res;
				st_o.fl[FL_CARRY]  = high_fix | add_lo[8];
				st_o.fl[FL_AUX]    = low_fix;
				st_o.fl[FL_SIGN]   = add_szp[2];
				st_o.fl[FL_ZERO]   = add_szp[1];
				st_o.fl[FL_PARITY] = add_szp[0];
			end
			icd_decimal_adjust_sub_op: begin
				st_o.acc[7:0]  = sub_res;
				st_o.fl[FL_CARRY]  = high_fix | sub_lo[8];
				st_o.fl[FL_AUX]    = low_fix;
				st_o.fl[FL_SIGN]   = sub_szp[2];
				st_o.fl[FL_ZERO]   = sub_szp[1];
				st_o.fl[FL_PARITY] = sub_szp[0];
			end
			default: begin
				st_o = st_i;
			end
		endcase
	end

endmodule : icd_exec

// [rtl/icd_pkg.sv]
package icd_pkg;

	// Register byte offsets (one aligned word each)
	localparam logic [4:0] REG_CTRL   = 5'h00;
	localparam logic [4:0] REG_INSN   = 5'h04;
	localparam logic [4:0] REG_ACC    = 5'h08;
	localparam logic [4:0] REG_DATA   = 5'h0c;
	localparam logic [4:0] REG_FLAGS  = 5'h10;
	localparam logic [4:0] REG_STATUS = 5'h14;

	// Control fields
	localparam int CTRL_START = 0;
	localparam int CTRL_OP32  = 1;
	localparam int CTRL_MISS  = 2;

	// Status fields
	localparam int ST_BUSY    = 0;
	localparam int ST_DONE    = 1;
	localparam int ST_ILLEGAL = 2;
	localparam int ST_OP_LSB  = 8;
	localparam int ST_MSK_LSB = 16;
	localparam int ST_CYC_LSB = 24;

	// Compact flag positions, in FLAGS and in every flag-effect mask
	localparam int FL_CARRY  = 0;
	localparam int FL_PARITY = 1;
	localparam int FL_AUX    = 2;
	localparam int FL_ZERO   = 3;
	localparam int FL_SIGN   = 4;
	localparam int FL_OVER   = 5;
	localparam int FL_W      = 6;

	localparam logic [FL_W-1:0] FLAGS_RST  = 6'h00;
	localparam logic [FL_W-1:0] MSK_NONE   = 6'h00;
	localparam logic [FL_W-1:0] MSK_CARRY  = 6'h01;
	localparam logic [FL_W-1:0] MSK_ARITH  = 6'h3f;
	localparam logic [FL_W-1:0] MSK_DECADJ = 6'h1f;
	localparam logic [FL_W-1:0] MSK_DECR   = 6'h3e;

	// Opcode bytes and bit patterns
	localparam logic [7:0] OPC_CARRY_INV = 8'hf5;
	localparam logic [7:0] OPC_SIGN_EXT  = 8'h99;
	localparam logic [7:0] OPC_DEC_ADD   = 8'h27;
	localparam logic [7:0] OPC_DEC_SUB   = 8'h2f;
	localparam logic [7:0] OPC_ESCAPE    = 8'h0f;
	localparam logic [5:0] PAT_CMP_RM    = 6'h0e;  // 0011_10xx
	localparam logic [6:0] PAT_CMP_ACC   = 7'h1e;  // 0011_110w
	localparam logic [5:0] PAT_CMP_IMM   = 6'h20;  // 1000_00sw
	localparam logic [6:0] PAT_XCHG      = 7'h58;  // 1011_000w
	localparam logic [6:0] PAT_DEC_RM    = 7'h7f;  // 1111_111w
	localparam logic [4:0] PAT_DEC_SHORT = 5'h09;  // 0100_1reg
	localparam logic [6:0] PAT_DIV       = 7'h7b;  // 1111_011w
	localparam logic [1:0] MOD_REG       = 2'h3;
	localparam logic [2:0] RF_CMP_IMM    = 3'h7;
	localparam logic [2:0] RF_DEC        = 3'h1;
	localparam logic [2:0] RF_DIV        = 3'h6;

	// Decimal adjust constants
	localparam logic [7:0] DA_LOW_FIX  = 8'h06;
	localparam logic [7:0] DA_HIGH_FIX = 8'h60;
	localparam logic [3:0] DA_LOW_MAX  = 4'h9;
	localparam logic [7:0] DA_BYTE_MAX = 8'h99;

	// Execution clock counts
	localparam int CNT_W = 6;
	localparam logic [CNT_W-1:0] CYC_ONE       = 6'h01;
	localparam logic [CNT_W-1:0] CYC_MEM_HIT   = 6'h03;
	localparam logic [CNT_W-1:0] CYC_MEM_MISS  = 6'h05;
	localparam logic [CNT_W-1:0] CYC_XCHG_HIT  = 6'h05;
	localparam logic [CNT_W-1:0] CYC_XCHG_MISS = 6'h08;
	localparam logic [CNT_W-1:0] CYC_DECADJ    = 6'h04;
	localparam logic [CNT_W-1:0] CYC_DIV_B_REG = 6'h0e;  // 14
	localparam logic [CNT_W-1:0] CYC_DIV_B_MEM = 6'h0f;  // 15
	localparam logic [CNT_W-1:0] CYC_DIV_W_REG = 6'h16;  // 22
	localparam logic [CNT_W-1:0] CYC_DIV_W_MEM = 6'h17;  // 23
	localparam logic [CNT_W-1:0] CYC_DIV_D_REG = 6'h26;  // 38
	localparam logic [CNT_W-1:0] CYC_DIV_D_MEM = 6'h27;  // 39

	typedef enum logic [3:0] {
		icd_none_op,
		icd_carry_invert_op,
		icd_cmp_reg_op,
		icd_cmp_mem_op,
		icd_cmp_imm_op,
		icd_cmp_acc_op,
		icd_compare_exchange_op,
		icd_word_sign_extend_op,
		icd_decimal_adjust_add_op,
		icd_decimal_adjust_sub_op,
		icd_decrement_rm_op,
		icd_decrement_short_op,
		icd_divide_op
	} icd_op_t;

	typedef struct packed {
		logic [7:0] b0;
		logic [7:0] b1;
		logic [7:0] b2;
	} icd_insn_t;

	typedef struct packed {
		icd_op_t         op;
		logic            w;
		logic            mem;
		logic            legal;
		logic [FL_W-1:0] mask;
	} icd_dec_t;

	typedef struct packed {
		logic [31:0]     acc;
		logic [31:0]     dx;
		logic [FL_W-1:0] fl;
	} icd_arch_t;

endpackage : icd_pkg

// [tb/icd_core_chk.sv]
`timescale 1ns/100ps
module icd_core_chk import icd_pkg::*; (
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        srst_i,
	// Avalon-MM slave
	input  wire logic [4:0]  avs_address_i,
	input  wire logic        avs_read_i,
	input  wire logic        avs_write_i,
	input  wire logic [31:0] avs_writedata_i,
	input  wire logic [3:0]  avs_byteenable_i,
	input  wire logic [31:0] avs_readdata_o,
	input  wire logic        avs_waitrequest_o,
	// Execution status
	input  wire logic        busy_o,
	input  wire logic        done_o
);
	localparam int MAX_RUN = 39;
	logic [5:0] run_q;
	logic [5:0] run_d;
	wire        start_acc;

	// Accepted start command
	assign start_acc = avs_write_i && !avs_waitrequest_o && avs_address_i == REG_CTRL
		&& avs_byteenable_i[0] && avs_writedata_i[CTRL_START] && !busy_o;
	// Busy run length, saturating so a stuck busy stays visible
	assign run_d = !busy_o ? 6'h00 : (run_q == 6'h3f) ? run_q : run_q + 6'h01;

	// Busy run counter
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			run_q <= 6'h00;
		end else begin
			run_q <= run_d;
		end
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (srst_i);

	property p_rst_idle;
		disable iff (1'b0) srst_i |=> avs_waitrequest_o && !busy_o && !done_o
			&& avs_readdata_o == 32'h0;
	endproperty
	a_rst_idle: assert property (p_rst_idle) else $error("state not idle after reset");
	property p_wait_ans;
		(avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o;
	endproperty
	a_wait_ans: assert property (p_wait_ans) else $error("bus answer late");
	property p_wait_one;
		!avs_waitrequest_o |=> avs_waitrequest_o;
	endproperty
	a_wait_one: assert property (p_wait_one) else $error("waitrequest low too long");
	property p_wait_idle;
		!avs_read_i && !avs_write_i |=> avs_waitrequest_o;
	endproperty
	a_wait_idle: assert property (p_wait_idle) else $error("answer without request");
	property p_rd_hold;
		!avs_read_i |=> $stable(avs_readdata_o);
	endproperty
	a_rd_hold: assert property (p_rd_hold) else $error("read data moved without read");
	property p_start_busy;
		start_acc |=> ##[0:1] busy_o;
	endproperty
	a_start_busy: assert property (p_start_busy) else $error("start gave no busy");
	property p_no_overlap;
		!(busy_o && done_o);
	endproperty
	a_no_overlap: assert property (p_no_overlap) else $error("busy and done together");
	property p_done_after;
		$fell(busy_o) && !$past(srst_i) |-> done_o;
	endproperty
	a_done_after: assert property (p_done_after) else $error("no done at end of busy");
	property p_run_max;
		run_q <= MAX_RUN;
	endproperty
	a_run_max: assert property (p_run_max) else $error("busy run too long");
	property p_busy_cause;
		$rose(busy_o) |-> $past(avs_write_i, 1) || $past(avs_write_i, 2);
	endproperty
	a_busy_cause: assert property (p_busy_cause) else $error("busy without write");
endmodule : icd_core_chk

// [tb/tb_integer_compare_adjust_divide_decode.sv]
`timescale 1ns/100ps
module tb_integer_compare_adjust_divide_decode import icd_pkg::*; ();
	logic        clk_i            = 1'b0;
	logic        srst_i           = 1'b1;
	logic [4:0]  avs_address_i    = 5'h00;
	logic        avs_read_i       = 1'b0;
	logic        avs_write_i      = 1'b0;
	logic [31:0] avs_writedata_i  = 32'h0;
	logic [3:0]  avs_byteenable_i = 4'h0;
	logic [31:0] avs_readdata_o;
	logic        avs_waitrequest_o;
	logic        busy_o;
	logic        done_o;
	int          mismatches       = 0;
	int          checked          = 0;
	int          cycles           = 0;
	int          blen             = 0;
	int          rs;
	string       q_nm[$];
	logic [31:0] q_rd[$];
	logic [5:0]  q_cyc[$];

	// Clock
	always #5 clk_i = ~clk_i;

	icd_core u_dut (.clk_i(clk_i), .srst_i(srst_i), .avs_address_i(avs_address_i),
		.avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
		.avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
		.avs_waitrequest_o(avs_waitrequest_o), .busy_o(busy_o), .done_o(done_o));

	task automatic print_verdict;
		$display("mismatches=%0d checked=%0d", mismatches, checked);
		if (mismatches == 0 && checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : print_verdict

	task automatic cmp_rd(input string nm, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			mismatches++;
			$display("unexpected %s: expected %h seen %h", nm, exp, got);
		end
	endtask : cmp_rd

	task automatic cmp_len(input logic [5:0] exp, input logic [5:0] got);
		checked++;
		if (got !== exp) begin
			mismatches++;
			$display("unexpected busy length: expected %0d seen %0d", exp, got);
		end
	endtask : cmp_len

	// One bus transfer, held until waitrequest is sampled low at a rising edge
	task automatic av_go(input logic [4:0] a, input logic [31:0] d, input logic [3:0] be,
		input logic rd);
		@(posedge clk_i);
		avs_address_i <= a;
		avs_writedata_i <= d;
		avs_byteenable_i <= be;
		avs_read_i <= rd;
		avs_write_i <= !rd;
		do @(posedge clk_i); while (avs_waitrequest_o !== 1'b0);
		avs_read_i <= 1'b0;
		avs_write_i <= 1'b0;
	endtask : av_go

	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		av_go(a, d, 4'hf, 1'b0);
	endtask : wr

	task automatic rd(input logic [4:0] a, input string nm, input logic [31:0] exp);
		q_nm.push_back(nm);
		q_rd.push_back(exp);
		av_go(a, 32'h0, 4'hf, 1'b1);
	endtask : rd

	// Load state, start one instruction, check counts, mask and results
	task automatic run(input logic [23:0] insn, input logic [1:0] ctl, input logic [3:0] op,
		input logic [5:0] msk, input logic [5:0] cyc, input logic [7:0] a8,
		input logic [5:0] fl, input logic [7:0] xa8, input logic [5:0] xfl);
		logic [31:0] acc;
		logic [31:0] dat;
		logic [31:0] xdat;
		acc = $urandom();
		acc[7:0] = a8;
		dat = $urandom();
		xdat = dat;
		if (op == 4'd7) xdat = ctl[0] ? {32{acc[31]}} : {dat[31:16], {16{acc[15]}}};
		wr(REG_ACC, acc);
		wr(REG_DATA, dat);
		wr(REG_FLAGS, {26'h0, fl});
		wr(REG_INSN, {8'h0, insn});
		q_cyc.push_back(cyc);
		wr(REG_CTRL, {29'h0, ctl, 1'b1});
		if (cyc > 6'd20) wr(REG_INSN, 32'h0);
		repeat (2) @(posedge clk_i);
		do @(negedge clk_i); while (done_o !== 1'b1);
		rd(REG_STATUS, "status", {2'h0, cyc, 2'h0, msk, 4'h0, op, 5'h0, (op == 4'd0), 2'b10});
		rd(REG_ACC, "acc", {acc[31:8], xa8});
		rd(REG_DATA, "data", xdat);
		rd(REG_FLAGS, "flags", {26'h0, xfl});
		rd(REG_INSN, "insn", {8'h0, insn});
		rd(REG_CTRL, "ctrl", {29'h0, ctl, 1'b0});
	endtask : run

	// Result watcher: oldest note against each read answer and busy run
	always @(negedge clk_i) begin
		if (avs_read_i && avs_waitrequest_o === 1'b0 && q_rd.size() > 0)
			cmp_rd(q_nm.pop_front(), q_rd.pop_front(), avs_readdata_o);
		if (busy_o === 1'b1) blen++;
		else if (blen > 0 && q_cyc.size() > 0) begin
			cmp_len(q_cyc.pop_front(), blen[5:0]);
			blen = 0;
		end
	end

	// Hang guard
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 8000) begin
			mismatches++;
			print_verdict();
		end
	end

	// Main sequence
	initial begin
		rs = $urandom(38);
		repeat (20) @(posedge clk_i);
		srst_i <= 1'b0;
		rd(REG_STATUS, "status", 32'h0);
		rd(REG_FLAGS, "flags", 32'h0);
		wr(5'h18, 32'hffffffff);
		rd(5'h18, "unmapped", 32'h0);
		av_go(REG_FLAGS, 32'h3f, 4'he, 1'b0);
		rd(REG_FLAGS, "flags", 32'h0);
		wr(REG_CTRL, 32'h6);
		rd(REG_CTRL, "ctrl", 32'h6);
		run(24'hf50000, 2'b00, 4'd1, 6'h01, 6'd1, 8'h3c, 6'h2a, 8'h3c, 6'h2b);
		run(24'hf50000, 2'b00, 4'd1, 6'h01, 6'd1, 8'h3c, 6'h2b, 8'h3c, 6'h2a);
		run(24'h39c800, 2'b00, 4'd2, 6'h3f, 6'd1, 8'h5a, 6'h15, 8'h5a, 6'h15);
		run(24'h3ac000, 2'b01, 4'd2, 6'h3f, 6'd1, 8'h5a, 6'h15, 8'h5a, 6'h15);
		run(24'h3a0800, 2'b00, 4'd3, 6'h3f, 6'd3, 8'h11, 6'h15, 8'h11, 6'h15);
		run(24'h390800, 2'b10, 4'd3, 6'h3f, 6'd5, 8'h11, 6'h15, 8'h11, 6'h15);
		run(24'h83f800, 2'b00, 4'd4, 6'h3f, 6'd1, 8'h22, 6'h15, 8'h22, 6'h15);
		run(24'h803800, 2'b00, 4'd4, 6'h3f, 6'd3, 8'h22, 6'h15, 8'h22, 6'h15);
		run(24'h813800, 2'b10, 4'd4, 6'h3f, 6'd5, 8'h22, 6'h15, 8'h22, 6'h15);
		run(24'h3d0000, 2'b00, 4'd5, 6'h3f, 6'd1, 8'h22, 6'h15, 8'h22, 6'h15);
		run(24'h0fb1c8, 2'b00, 4'd6, 6'h3f, 6'd5, 8'h33, 6'h15, 8'h33, 6'h15);
		run(24'h0fb008, 2'b10, 4'd6, 6'h3f, 6'd8, 8'h33, 6'h15, 8'h33, 6'h15);
		run(24'h990000, 2'b01, 4'd7, 6'h00, 6'd1, 8'h44, 6'h3f, 8'h44, 6'h3f);
		run(24'h990000, 2'b00, 4'd7, 6'h00, 6'd1, 8'h44, 6'h00, 8'h44, 6'h00);
		run(24'h270000, 2'b00, 4'd8, 6'h1f, 6'd4, 8'h0f, 6'h20, 8'h15, 6'h24);
		run(24'h270000, 2'b00, 4'd8, 6'h1f, 6'd4, 8'h9a, 6'h00, 8'h00, 6'h0f);
		run(24'h2f0000, 2'b00, 4'd9, 6'h1f, 6'd4, 8'h0a, 6'h21, 8'ha4, 6'h35);
		run(24'h2f0000, 2'b00, 4'd9, 6'h1f, 6'd4, 8'h1f, 6'h00, 8'h19, 6'h04);
		run(24'hffc800, 2'b00, 4'd10, 6'h3e, 6'd1, 8'h55, 6'h01, 8'h55, 6'h01);
		run(24'hfe0800, 2'b10, 4'd10, 6'h3e, 6'd5, 8'h55, 6'h01, 8'h55, 6'h01);
		run(24'h480000, 2'b00, 4'd11, 6'h3e, 6'd1, 8'h55, 6'h01, 8'h55, 6'h01);
		run(24'hf6f000, 2'b00, 4'd12, 6'h00, 6'd14, 8'h66, 6'h15, 8'h66, 6'h15);
		run(24'hf73000, 2'b00, 4'd12, 6'h00, 6'd23, 8'h66, 6'h15, 8'h66, 6'h15);
		run(24'hf7f000, 2'b01, 4'd12, 6'h00, 6'd38, 8'h66, 6'h15, 8'h66, 6'h15);
		run(24'hf73000, 2'b01, 4'd12, 6'h00, 6'd39, 8'h66, 6'h15, 8'h66, 6'h15);
		run(24'hffc000, 2'b00, 4'd0, 6'h00, 6'd1, 8'h77, 6'h15, 8'h77, 6'h15);
		repeat (5) @(posedge clk_i);
		print_verdict();
	end
endmodule : tb_integer_compare_adjust_divide_decode

bind icd_core icd_core_chk u_chk (.clk_i(clk_i), .srst_i(srst_i),
	.avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
	.avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
	.avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
	.busy_o(busy_o), .done_o(done_o));
